/* shared/bcs_defs.svh */
// Offsets, field positions, reset values and rate figures of the clock source select block
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH

`define BCS_ADDR_W 16
`define BCS_OFF_REF_HIGH 16'h20F3
`define BCS_OFF_CTRL_LOW 16'h00F4
`define BCS_OFF_CTRL_HIGH 16'h20F4

`define BCS_RST_REF_HIGH 8'h00
`define BCS_RST_CTRL_LOW 8'h00
`define BCS_RST_CTRL_HIGH 8'h00

`define BCS_REF_CHOICE_MSB 7
`define BCS_REF_CHOICE_LSB 4
`define BCS_REF_RATE_BIT 3
`define BCS_RX_SYS_BIT 6
`define BCS_TX_SYS_BIT 5
`define BCS_TX_LINE_BIT 4
`define BCS_CLKOUT_MSB 3
`define BCS_CLKOUT_LSB 0

`define BCS_REF_CODE_DERIVED 4'h8
`define BCS_REF_CODE_EXTERNAL 4'h9

`define BCS_REF_KHZ_E1 2048
`define BCS_REF_KHZ_T1 1544

`define BCS_MASTER_KHZ 16384
`define BCS_PHASE_W 24

`endif

/* shared/bcs_pkg.sv */
// Types of the clock source select block
package bcs_pkg;
  typedef logic [7:0] bcs_byte_t;
  typedef logic [15:0] bcs_addr_t;
  typedef logic [7:0] bcs_port8_t;
  typedef enum logic [1:0] {
    BCS_SRC_RECOVERED = 2'b00,
    BCS_SRC_DERIVED = 2'b01,
    BCS_SRC_EXTERNAL = 2'b11,
    BCS_SRC_NONE = 2'b10
  } bcs_ref_src_e;
endpackage : bcs_pkg

/* logic/bcs_clock_select.sv */
// Clock source selection, backplane reference choice and clock-out divider
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.svh"

module bcs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage is read outside
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : bcs_sync2

module bcs_nco (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Count on both edges of the sampled master clock
  input wire logic edge_seen,
  input wire logic [`BCS_PHASE_W-1:0] step,
  output logic wave
);
  logic [`BCS_PHASE_W-1:0] phase_q;
  logic [`BCS_PHASE_W-1:0] phase_d;

  assign phase_d = edge_seen ? phase_q + step : phase_q;
  assign wave = phase_q[`BCS_PHASE_W-1];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_d;
    end
  end
endmodule : bcs_nco

module bcs_clock_select (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire bcs_pkg::bcs_addr_t reg_addr,
  input wire bcs_pkg::bcs_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output bcs_pkg::bcs_byte_t reg_rdata,
  // Master clock and recovered line clocks of ports 9 to 16
  input wire logic master_clock_pin,
  input wire bcs_pkg::bcs_port8_t rx_recovered_clock_high,
  // Backplane clocks from the generators
  input wire logic backplane_clock_low,
  input wire logic backplane_clock_high,
  // Per-port clock pins, ports 1 to 8 and 9 to 16
  input wire bcs_pkg::bcs_port8_t rx_system_clock_pin_low,
  input wire bcs_pkg::bcs_port8_t rx_system_clock_pin_high,
  input wire bcs_pkg::bcs_port8_t tx_system_clock_pin_low,
  input wire bcs_pkg::bcs_port8_t tx_system_clock_pin_high,
  input wire bcs_pkg::bcs_port8_t tx_line_clock_pin_low,
  input wire bcs_pkg::bcs_port8_t tx_line_clock_pin_high,
  // Reference clock pin, two-way
  input wire logic reference_clock_pin_in,
  output logic reference_clock_pin_out,
  output logic reference_clock_pin_oe,
  // Selected clocks to ports
  output bcs_pkg::bcs_port8_t rx_system_clock_low,
  output bcs_pkg::bcs_port8_t rx_system_clock_high,
  output bcs_pkg::bcs_port8_t tx_system_clock_low,
  output bcs_pkg::bcs_port8_t tx_system_clock_high,
  output bcs_pkg::bcs_port8_t tx_line_clock_low,
  output bcs_pkg::bcs_port8_t tx_line_clock_high,
  // Backplane high reference to its generator
  output logic backplane_ref_high,
  output logic backplane_ref_rate,
  output logic backplane_ref_valid,
  // Clock output pin
  output logic clock_out_pin
);
  import bcs_pkg::*;

  localparam int SYNC_W = 60;

  // Step per master edge: rate * 2^(W-1) / master, two edges per master period
  function automatic logic [`BCS_PHASE_W-1:0] rate_step(input int khz);
    logic [47:0] wide;
    wide = (48'(khz) << (`BCS_PHASE_W - 1)) / 48'(`BCS_MASTER_KHZ);
    return wide[`BCS_PHASE_W-1:0];
  endfunction : rate_step

  function automatic int clkout_khz(input logic [3:0] code);
    int khz;
    khz = 0;
    case (code)
      4'h0: khz = 2048;
      4'h1: khz = 4096;
      4'h2: khz = 8192;
      4'h3: khz = 16384;
      4'h4: khz = 1544;
      4'h5: khz = 3088;
      4'h6: khz = 6176;
      4'h7: khz = 12352;
      4'h8: khz = 1536;
      4'h9: khz = 3072;
      4'hA: khz = 6144;
      4'hB: khz = 12288;
      4'hC: khz = 32;
      4'hD: khz = 64;
      4'hE: khz = 128;
      default: khz = 256;
    endcase
    return khz;
  endfunction : clkout_khz

  // Registers
  bcs_byte_t ref_high_q;
  bcs_byte_t ctrl_low_q;
  bcs_byte_t ctrl_high_q;
  bcs_byte_t rdata_q;

  // Synchronised pins
  logic [SYNC_W-1:0] async_bus;
  logic [SYNC_W-1:0] sync_bus;
  logic mclk_s;
  logic refpin_s;
  logic bp_low_s;
  logic bp_high_s;
  bcs_port8_t recov_s;
  bcs_port8_t rxp_lo_s;
  bcs_port8_t rxp_hi_s;
  bcs_port8_t txp_lo_s;
  bcs_port8_t txp_hi_s;
  bcs_port8_t tlp_lo_s;
  bcs_port8_t tlp_hi_s;

  assign async_bus = {master_clock_pin, reference_clock_pin_in, backplane_clock_low,
                      backplane_clock_high, rx_recovered_clock_high,
                      rx_system_clock_pin_low, rx_system_clock_pin_high,
                      tx_system_clock_pin_low, tx_system_clock_pin_high,
                      tx_line_clock_pin_low, tx_line_clock_pin_high};
  assign {mclk_s, refpin_s, bp_low_s, bp_high_s, recov_s, rxp_lo_s, rxp_hi_s,
          txp_lo_s, txp_hi_s, tlp_lo_s, tlp_hi_s} = sync_bus;

  bcs_sync2 #(.W(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  // Address decode
  wire hit_ref_high = (reg_addr == `BCS_OFF_REF_HIGH);
  wire hit_ctrl_low = (reg_addr == `BCS_OFF_CTRL_LOW);
  wire hit_ctrl_high = (reg_addr == `BCS_OFF_CTRL_HIGH);
  bcs_byte_t rd_mux;
  assign rd_mux = hit_ref_high ? {ref_high_q[7:3], 3'h0} :
                  hit_ctrl_low ? {1'b0, ctrl_low_q[6:0]} :
                  hit_ctrl_high ? {1'b0, ctrl_high_q[6:4], 4'h0} :
                  8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_high_q <= `BCS_RST_REF_HIGH;
      ctrl_low_q <= `BCS_RST_CTRL_LOW;
      ctrl_high_q <= `BCS_RST_CTRL_HIGH;
      rdata_q <= 8'h00;
    end else begin
      if (reg_wr && hit_ref_high) begin
        ref_high_q <= {reg_wdata[7:3], 3'h0};
      end
      if (reg_wr && hit_ctrl_low) begin
        ctrl_low_q <= {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && hit_ctrl_high) begin
        ctrl_high_q <= {1'b0, reg_wdata[6:4], 4'h0};
      end
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Fields
  wire [3:0] ref_choice = ref_high_q[`BCS_REF_CHOICE_MSB:`BCS_REF_CHOICE_LSB];
  wire ref_rate = ref_high_q[`BCS_REF_RATE_BIT];
  wire [3:0] clkout_code = ctrl_low_q[`BCS_CLKOUT_MSB:`BCS_CLKOUT_LSB];

  // Master clock edges; a sampled edge gives jitter of one ref_clk period
  logic mclk_prev_q;
  wire mclk_edge = mclk_s ^ mclk_prev_q;

  // Both step tables are constants, so the muxes below stay small
  logic [`BCS_PHASE_W-1:0] clkout_step;
  logic [`BCS_PHASE_W-1:0] derived_step;
  always_comb begin
    clkout_step = rate_step(clkout_khz(clkout_code));
    derived_step = ref_rate ? rate_step(`BCS_REF_KHZ_T1) : rate_step(`BCS_REF_KHZ_E1);
  end

  logic clkout_wave;
  logic derived_wave;

  bcs_nco u_clkout_nco (
    .ref_clk(ref_clk),
    .srst(srst),
    .edge_seen(mclk_edge),
    .step(clkout_step),
    .wave(clkout_wave)
  );

  bcs_nco u_derived_nco (
    .ref_clk(ref_clk),
    .srst(srst),
    .edge_seen(mclk_edge),
    .step(derived_step),
    .wave(derived_wave)
  );

  // Reference source classification
  bcs_ref_src_e ref_src;
  assign ref_src = (ref_choice[3] == 1'b0) ? BCS_SRC_RECOVERED :
                   (ref_choice == `BCS_REF_CODE_DERIVED) ? BCS_SRC_DERIVED :
                   (ref_choice == `BCS_REF_CODE_EXTERNAL) ? BCS_SRC_EXTERNAL :
                   BCS_SRC_NONE;

  logic ref_sel;
  always_comb begin
    case (ref_src)
      BCS_SRC_RECOVERED: ref_sel = recov_s[ref_choice[2:0]];
      BCS_SRC_DERIVED: ref_sel = derived_wave;
      BCS_SRC_EXTERNAL: ref_sel = refpin_s;
      default: ref_sel = 1'b0;
    endcase
  end

  wire pin_drive = (ref_src == BCS_SRC_DERIVED);

  // Port clock selection
  bcs_port8_t rx_lo_d;
  bcs_port8_t rx_hi_d;
  bcs_port8_t tx_lo_d;
  bcs_port8_t tx_hi_d;
  bcs_port8_t tl_lo_d;
  bcs_port8_t tl_hi_d;
  assign rx_lo_d = ctrl_low_q[`BCS_RX_SYS_BIT] ? {8{bp_low_s}} : rxp_lo_s;
  assign tx_lo_d = ctrl_low_q[`BCS_TX_SYS_BIT] ? {8{bp_low_s}} : txp_lo_s;
  assign tl_lo_d = ctrl_low_q[`BCS_TX_LINE_BIT] ? {8{refpin_s}} : tlp_lo_s;
  assign rx_hi_d = ctrl_high_q[`BCS_RX_SYS_BIT] ? {8{bp_high_s}} : rxp_hi_s;
  assign tx_hi_d = ctrl_high_q[`BCS_TX_SYS_BIT] ? {8{bp_high_s}} : txp_hi_s;
  assign tl_hi_d = ctrl_high_q[`BCS_TX_LINE_BIT] ? {8{refpin_s}} : tlp_hi_s;

  // Output flops; selected clocks lag their pins by three ref_clk cycles, the derived reference its NCO by one
  logic ref_out_q;
  logic ref_oe_q;
  logic bp_ref_q;
  logic bp_rate_q;
  logic bp_valid_q;
  logic clkout_q;
  bcs_port8_t rx_lo_q;
  bcs_port8_t rx_hi_q;
  bcs_port8_t tx_lo_q;
  bcs_port8_t tx_hi_q;
  bcs_port8_t tl_lo_q;
  bcs_port8_t tl_hi_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mclk_prev_q <= 1'b0;
      ref_out_q <= 1'b0;
      ref_oe_q <= 1'b0;
      bp_ref_q <= 1'b0;
      bp_rate_q <= 1'b0;
      bp_valid_q <= 1'b0;
      clkout_q <= 1'b0;
      rx_lo_q <= 8'h00;
      rx_hi_q <= 8'h00;
      tx_lo_q <= 8'h00;
      tx_hi_q <= 8'h00;
      tl_lo_q <= 8'h00;
      tl_hi_q <= 8'h00;
    end else begin
      mclk_prev_q <= mclk_s;
      ref_out_q <= pin_drive & derived_wave;
      ref_oe_q <= pin_drive;
      bp_ref_q <= ref_sel;
      bp_rate_q <= ref_rate;
      bp_valid_q <= (ref_src != BCS_SRC_NONE);
      clkout_q <= clkout_wave;
      rx_lo_q <= rx_lo_d;
      rx_hi_q <= rx_hi_d;
      tx_lo_q <= tx_lo_d;
      tx_hi_q <= tx_hi_d;
      tl_lo_q <= tl_lo_d;
      tl_hi_q <= tl_hi_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reference_clock_pin_out = ref_out_q;
  assign reference_clock_pin_oe = ref_oe_q;
  assign backplane_ref_high = bp_ref_q;
  assign backplane_ref_rate = bp_rate_q;
  assign backplane_ref_valid = bp_valid_q;
  assign clock_out_pin = clkout_q;
  assign rx_system_clock_low = rx_lo_q;
  assign rx_system_clock_high = rx_hi_q;
  assign tx_system_clock_low = tx_lo_q;
  assign tx_system_clock_high = tx_hi_q;
  assign tx_line_clock_low = tl_lo_q;
  assign tx_line_clock_high = tl_hi_q;
endmodule : bcs_clock_select

`default_nettype wire

/* dv/bcs_clock_select_asserts.sv */
// Checker of the clock source select block
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.svh"
module bcs_clock_select_asserts (
  // Clock, reset and register port
  input wire logic ref_clk,
  input wire logic srst,
  input wire bcs_pkg::bcs_addr_t reg_addr,
  input wire bcs_pkg::bcs_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire bcs_pkg::bcs_byte_t reg_rdata,
  // Clock pins in
  input wire bcs_pkg::bcs_port8_t rx_recovered_clock_high,
  input wire logic backplane_clock_low,
  input wire bcs_pkg::bcs_port8_t rx_system_clock_pin_low,
  input wire bcs_pkg::bcs_port8_t tx_line_clock_pin_low,
  input wire logic reference_clock_pin_in,
  // Selected clocks out
  input wire logic reference_clock_pin_oe,
  input wire bcs_pkg::bcs_port8_t rx_system_clock_low,
  input wire bcs_pkg::bcs_port8_t tx_line_clock_low,
  input wire logic backplane_ref_high,
  input wire logic backplane_ref_rate,
  input wire logic backplane_ref_valid
);
  import bcs_pkg::*;
  bcs_byte_t ref_q, low_q, high_q;
  logic [2:0] age_q;
  wire [3:0] code = ref_q[7:4];
  wire rec_pick = rx_recovered_clock_high[ref_q[6:4]];
  wire bcs_port8_t rx_low_exp = low_q[6] ? {8{backplane_clock_low}} :
    rx_system_clock_pin_low;
  wire bcs_port8_t line_low_exp = low_q[4] ? {8{reference_clock_pin_in}} :
    tx_line_clock_pin_low;
  // Path checks wait for the synchronisers to flush after any write
  wire settled = (age_q == 3'h7);
  wire bcs_byte_t rd_exp = (reg_addr == `BCS_OFF_REF_HIGH) ? ref_q :
    (reg_addr == `BCS_OFF_CTRL_LOW) ? low_q : (reg_addr == `BCS_OFF_CTRL_HIGH) ? high_q : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (srst || reg_wr) age_q <= 3'h0;
    else if (!settled) age_q <= age_q + 3'h1;
    if (srst) {ref_q, low_q, high_q} <= 24'h000000;
    else if (reg_wr && reg_addr == `BCS_OFF_REF_HIGH) ref_q <= reg_wdata & 8'hF8;
    else if (reg_wr && reg_addr == `BCS_OFF_CTRL_LOW) low_q <= reg_wdata & 8'h7F;
    else if (reg_wr && reg_addr == `BCS_OFF_CTRL_HIGH) high_q <= reg_wdata & 8'h70;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_read_data: assert property ($past(reg_rd) |-> reg_rdata == $past(rd_exp))
    else $error("read data wrong");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_pin_drive: assert property (!$past(srst) |-> reference_clock_pin_oe == ($past(code) == 4'h8))
    else $error("reference pin drive wrong");
  a_ref_valid: assert property (!$past(srst) |-> backplane_ref_valid == ($past(code) < 4'hA))
    else $error("reference valid wrong");
  a_rate_copy: assert property (!$past(srst) |-> backplane_ref_rate == $past(ref_q[3]))
    else $error("reference rate wrong");
  a_ref_recovered: assert property (settled && code < 4'h8 |-> backplane_ref_high == $past(rec_pick, 3))
    else $error("recovered reference wrong");
  a_ref_external: assert property (settled && code == 4'h9
    |-> backplane_ref_high == $past(reference_clock_pin_in, 3))
    else $error("external reference wrong");
  // A later write may legally change the output two edges on, so look only at this edge
  a_ref_reserved: assert property (settled && code > 4'h9
    |-> !backplane_ref_high && !reference_clock_pin_oe)
    else $error("reserved code gives a reference");
  a_rx_low_sel: assert property (settled |-> rx_system_clock_low == $past(rx_low_exp, 3))
    else $error("rx system clock low wrong");
  a_line_low_sel: assert property (settled |-> tx_line_clock_low == $past(line_low_exp, 3))
    else $error("tx line clock low wrong");
endmodule : bcs_clock_select_asserts
bind bcs_clock_select bcs_clock_select_asserts u_bcs_clock_select_asserts (.*);
`default_nettype wire

/* dv/bcs_clock_select_tb_top.sv */
// Testbench of the clock source select block
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.svh"
module bcs_clock_select_tb_top;
  import bcs_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, master_clock_pin = 1'b0;
  logic backplane_clock_low = 1'b1, backplane_clock_high = 1'b0, ref_drive = 1'b1;
  logic reference_clock_pin_out, reference_clock_pin_oe, backplane_ref_high, backplane_ref_rate;
  logic backplane_ref_valid, clock_out_pin;
  bcs_addr_t reg_addr = 16'h0000;
  bcs_byte_t reg_wdata = 8'h00, reg_rdata;
  bcs_port8_t rx_recovered_clock_high = 8'hB4, rx_system_clock_pin_low = 8'h5A;
  bcs_port8_t rx_system_clock_pin_high = 8'h3C, tx_system_clock_pin_low = 8'hC3;
  bcs_port8_t tx_system_clock_pin_high = 8'h69, tx_line_clock_pin_low = 8'h96;
  bcs_port8_t tx_line_clock_pin_high = 8'h0F, rx_system_clock_low, rx_system_clock_high;
  bcs_port8_t tx_system_clock_low, tx_system_clock_high, tx_line_clock_low, tx_line_clock_high;
  // Wire level of the two-way reference pin
  wire reference_clock_pin_in = reference_clock_pin_oe ? reference_clock_pin_out : ref_drive;
  int num_errors = 0, check_count = 0, cyc = 0;
  bcs_addr_t regs [3] = '{`BCS_OFF_REF_HIGH, `BCS_OFF_CTRL_LOW, `BCS_OFF_CTRL_HIGH};
  // Address, write data, read-back expected
  logic [31:0] rows [6] = '{{16'h20F3, 16'hFFF8}, {16'h00F4, 16'hFF7F}, {16'h20F4, 16'hFF70},
    {16'h00F5, 16'hAA00}, {16'h20F4, 16'h8F00}, {16'h20F3, 16'h4740}};
  // Clock-out code, lowest and highest rising-edge count in 1024 cycles
  logic [19:0] clk_rows [8] = '{{4'h0, 16'h0F11}, {4'h1, 16'h1F21}, {4'h3, 16'h7F81},
    {4'h4, 16'h0B0D}, {4'h9, 16'h1719}, {4'hF, 16'h0103}, {4'h7, 16'h5F62},
    {4'hA, 16'h2F31}};
  bcs_clock_select u_bcs_clock_select (.*);
  always #20 ref_clk = ~ref_clk;
  // Master runs slow enough to be sampled: period of 8 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc[1:0] == 2'h3) master_clock_pin <= ~master_clock_pin;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input bcs_addr_t a, input bcs_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input bcs_addr_t a, input bcs_byte_t exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, exp);
  endtask : rd
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic rate_chk(input logic [19:0] r);
    logic p_out, p_ref;
    logic [7:0] n_out, n_ref, n_pin;
    wr(`BCS_OFF_CTRL_LOW, {4'h0, r[19:16]});
    settle();
    n_out = 8'h00;
    n_ref = 8'h00;
    n_pin = 8'h00;
    p_out = clock_out_pin;
    p_ref = backplane_ref_high;
    repeat (1024) begin
      @(negedge ref_clk);
      n_out += {7'h00, clock_out_pin & ~p_out};
      n_ref += {7'h00, backplane_ref_high & ~p_ref};
      n_pin += {7'h00, reference_clock_pin_out ^ backplane_ref_high};
      p_out = clock_out_pin;
      p_ref = backplane_ref_high;
    end
    check({7'h00, n_out >= r[15:8] && n_out <= r[7:0]}, 8'h01);
    check({7'h00, n_ref >= 8'h0F && n_ref <= 8'h11}, 8'h01);
    check(n_pin, 8'h00);
  endtask : rate_chk
  task automatic print_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(regs[i], 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], rows[i][7:0]);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      {rx_system_clock_pin_low, rx_system_clock_pin_high, tx_system_clock_pin_low,
        tx_system_clock_pin_high, tx_line_clock_pin_low, tx_line_clock_pin_high} <=
        ~{rx_system_clock_pin_low, rx_system_clock_pin_high, tx_system_clock_pin_low,
        tx_system_clock_pin_high, tx_line_clock_pin_low, tx_line_clock_pin_high};
      backplane_clock_low <= k[0];
      backplane_clock_high <= ~k[1];
      ref_drive <= k[2];
      wr(`BCS_OFF_CTRL_LOW, {1'b0, k[2:0], 4'h0});
      wr(`BCS_OFF_CTRL_HIGH, {1'b0, ~k[2:0], 4'h0});
      settle();
      check(rx_system_clock_low, k[2] ? {8{backplane_clock_low}} : rx_system_clock_pin_low);
      check(tx_system_clock_low, k[1] ? {8{backplane_clock_low}} : tx_system_clock_pin_low);
      check(tx_line_clock_low, k[0] ? {8{reference_clock_pin_in}} : tx_line_clock_pin_low);
      check(rx_system_clock_high, k[2] ? rx_system_clock_pin_high : {8{backplane_clock_high}});
      check(tx_system_clock_high, k[1] ? tx_system_clock_pin_high : {8{backplane_clock_high}});
      check(tx_line_clock_high, k[0] ? tx_line_clock_pin_high : {8{reference_clock_pin_in}});
    end
    for (int c = 0; c < 16; c++) begin
      @(posedge ref_clk);
      rx_recovered_clock_high <= {rx_recovered_clock_high[6:0], rx_recovered_clock_high[7]};
      ref_drive <= c[1];
      wr(`BCS_OFF_REF_HIGH, {c[3:0], c[0], 3'h0});
      settle();
      check({5'h00, reference_clock_pin_oe, backplane_ref_valid, backplane_ref_rate},
        {5'h00, c == 8, c < 10, c[0]});
      if (c != 8) check({7'h00, backplane_ref_high},
        {7'h00, c < 8 ? rx_recovered_clock_high[c[2:0]] : (c == 9 && ref_drive)});
    end
    wr(`BCS_OFF_REF_HIGH, 8'h80);
    for (int i = 0; i < 8; i++) rate_chk(clk_rows[i]);
    // Second reset in mid-run with the pin driven
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(regs[i], 8'h00);
    check({7'h00, reference_clock_pin_oe}, 8'h00);
    print_verdict();
  end
endmodule : bcs_clock_select_tb_top
`default_nettype wire
